// file: adc_readout_pkg.sv
package adc_readout_pkg;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int SLAVE_SCLK_MAX_MHZ = 40;
	localparam int SPI_MAX_MBPS = 17;
	// least host half period that keeps the spi rate at or below the limit
	localparam int HOST_HALF = (CLK_MHZ + 2 * SPI_MAX_MBPS - 1) / (2 * SPI_MAX_MBPS);
	// shortest external clock level the device can still see
	localparam int DEV_MIN_HALF = CLK_MHZ / (2 * SLAVE_SCLK_MAX_MHZ);
	localparam int MASTER_HALF = 2;
	localparam int SLOW_HALF = 8;
	localparam int PAR_LOW = 3;
	// result and transfer shape
	localparam int RES_W = 18;
	localparam logic [4:0] RES_BITS = 5'h12;
	localparam logic [4:0] SPI_BITS = 5'h18;
	localparam int WORD_W = 32;
	localparam int PAD_W = WORD_W - RES_W;
	localparam int W16 = 16;
	localparam int W8 = 8;
	localparam logic [1:0] LAST16 = 2'h1;
	localparam logic [1:0] LAST8 = 2'h2;
	// {iface_sel_hi, iface_sel_lo}
	localparam logic [1:0] SEL_P18 = 2'h0;
	localparam logic [1:0] SEL_P16 = 2'h1;
	localparam logic [1:0] SEL_P8 = 2'h2;
	localparam logic [1:0] SEL_SERIAL = 2'h3;
	// host registers
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] DATA_OFS = 12'h008;
	localparam int CTRL_SEL_LO = 0;
	localparam int CTRL_SEL_HI = 1;
	localparam int CTRL_CLKSRC = 2;
	localparam int CTRL_RDC = 3;
	localparam int CTRL_DIV = 4;
	localparam int CTRL_SCLK_INV = 5;
	localparam int CTRL_SYNC_INV = 6;
	localparam int CTRL_IN_BUSY = 7;
	localparam int CTRL_START = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_LATE = 2;
	localparam int ST_ACTIVE = 3;
endpackage

// file: readout_if.sv
`timescale 1ns/100ps
interface readout_if;
	logic cs_n, rd_n, iface_sel_lo, iface_sel_hi, clock_source_select;
	logic read_timing_chain_in, clock_divide_select, sclk_invert, sync_invert, host_sclk;
	logic dev_sclk, dev_sclk_oe_n, sync, sync_oe_n, serial_result_out, sdo_oe_n;
	logic [17:0] data;
	logic data_oe_n, busy, late_read_flag;
	modport device(input cs_n, rd_n, iface_sel_lo, iface_sel_hi, clock_source_select,
		read_timing_chain_in, clock_divide_select, sclk_invert, sync_invert, host_sclk,
		output dev_sclk, dev_sclk_oe_n, sync, sync_oe_n, serial_result_out, sdo_oe_n,
		data, data_oe_n, busy, late_read_flag);
	modport host(output cs_n, rd_n, iface_sel_lo, iface_sel_hi, clock_source_select,
		read_timing_chain_in, clock_divide_select, sclk_invert, sync_invert, host_sclk,
		input dev_sclk, dev_sclk_oe_n, sync, sync_oe_n, serial_result_out, sdo_oe_n,
		data, data_oe_n, busy, late_read_flag);
endinterface

// file: adc_readout_device.sv
`timescale 1ns/100ps
module adc_readout_device #(
	parameter int MASTER_HALF = adc_readout_pkg::MASTER_HALF,
	parameter int SLOW_HALF = adc_readout_pkg::SLOW_HALF
) (
	input wire logic pclk,
	input wire logic presetn,
	readout_if.device link,
	input wire logic conv_busy,
	input wire logic [adc_readout_pkg::RES_W-1:0] conv_result
);
	localparam int RW = adc_readout_pkg::RES_W;

	if (MASTER_HALF < 1 || SLOW_HALF < MASTER_HALF || SLOW_HALF > 255) begin : g_chk
		$error("master clock half periods out of range");
	end

	logic [RW-1:0] res, next_res, sr, next_sr, par, next_par, ld_val;
	logic [4:0] cnt, next_cnt;
	logic [7:0] div, next_div, half;
	logic [1:0] idx, next_idx, last;
	logic run, next_run, hold, next_hold, in_conv, next_in_conv;
	logic chain_en, next_chain_en, chain_q, next_chain_q, late, next_late;
	logic msclk, next_msclk, busy_q, sclk_q, rd_q;
	logic serial, selected, master, slave, conv_fall, conv_rise, m_tick, rise, fall, ld;
	logic [1:0] width;
	logic [adc_readout_pkg::WORD_W-1:0] word, sh16, sh8;

	always_comb begin
		width = {link.iface_sel_hi, link.iface_sel_lo};
		serial = width == adc_readout_pkg::SEL_SERIAL;
		selected = !link.cs_n && !link.rd_n;
		master = serial && !link.clock_source_select;
		slave = serial && link.clock_source_select;
		conv_fall = busy_q && !conv_busy;
		conv_rise = !busy_q && conv_busy;
		half = link.clock_divide_select ? 8'(SLOW_HALF - 1) : 8'(MASTER_HALF - 1);
		m_tick = master && run && div == 8'h00;
		// pin edges seen one cycle late; any idle level or a free-running clock works
		rise = (m_tick && !msclk) || (slave && run && link.host_sclk && !sclk_q);
		fall = (m_tick && msclk) || (slave && run && !link.host_sclk && sclk_q);
		next_res = res;
		next_sr = sr;
		next_cnt = cnt;
		next_div = div;
		next_idx = idx;
		next_run = run;
		next_hold = hold;
		next_in_conv = in_conv;
		next_chain_en = chain_en;
		next_chain_q = chain_q;
		next_msclk = msclk;
		next_late = 1'b0;
		ld = 1'b0;
		ld_val = res;
		if (m_tick) begin
			next_div = half;
			next_msclk = !msclk;
		end else if (master && run) begin
			next_div = div - 8'h01;
		end
		if (rise) begin
			next_chain_q = chain_en && link.read_timing_chain_in;
		end
		if (fall) begin
			next_sr = {sr[RW-2:0], chain_q};
			if (cnt != adc_readout_pkg::RES_BITS) begin
				next_cnt = cnt + 5'h01;
			end
			if (master && cnt == adc_readout_pkg::RES_BITS - 5'h01) begin
				next_run = 1'b0;
				next_hold = 1'b0;
			end
		end
		if (slave && run && in_conv && conv_fall && cnt != adc_readout_pkg::RES_BITS) begin
			next_late = 1'b1;
		end
		if (master && !run) begin
			if (!link.read_timing_chain_in && conv_fall) begin
				ld = 1'b1;
				ld_val = conv_result;
				next_hold = 1'b1;
			end else if (link.read_timing_chain_in && conv_rise) begin
				ld = 1'b1;
			end
			next_chain_en = 1'b0;
		end
		if (slave && !run && selected) begin
			ld = 1'b1;
			ld_val = conv_fall ? conv_result : res;
			next_in_conv = conv_busy;
			next_chain_en = !conv_busy;
		end
		if (ld) begin
			next_sr = ld_val;
			next_cnt = 5'h00;
			next_run = 1'b1;
			next_msclk = 1'b0;
			next_div = half;
			next_chain_q = 1'b0;
		end
		if ((slave && run && !selected) || !serial) begin
			next_run = 1'b0;
			next_hold = 1'b0;
		end
		// parallel: each read that ends while cs_n stays low steps to the next chunk
		unique case (width)
			adc_readout_pkg::SEL_P16: last = adc_readout_pkg::LAST16;
			adc_readout_pkg::SEL_P8: last = adc_readout_pkg::LAST8;
			default: last = 2'h0;
		endcase
		if (!link.cs_n && link.rd_n && !rd_q) begin
			next_idx = (idx >= last) ? 2'h0 : idx + 2'h1;
		end
		if (conv_fall) begin
			next_res = conv_result;
			next_idx = 2'h0;
		end
		word = {res, {adc_readout_pkg::PAD_W{1'b0}}};
		sh16 = word << (adc_readout_pkg::W16 * idx);
		sh8 = word << (adc_readout_pkg::W8 * idx);
		unique case (width)
			adc_readout_pkg::SEL_P16: begin
				next_par = {{(RW - adc_readout_pkg::W16){1'b0}},
					sh16[adc_readout_pkg::WORD_W-1 -: adc_readout_pkg::W16]};
			end
			adc_readout_pkg::SEL_P8: begin
				next_par = {{(RW - adc_readout_pkg::W8){1'b0}},
					sh8[adc_readout_pkg::WORD_W-1 -: adc_readout_pkg::W8]};
			end
			default: next_par = res;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res <= '0;
			sr <= '0;
			par <= '0;
			cnt <= 5'h00;
			div <= 8'h00;
			idx <= 2'h0;
			run <= 1'b0;
			hold <= 1'b0;
			in_conv <= 1'b0;
			chain_en <= 1'b0;
			chain_q <= 1'b0;
			late <= 1'b0;
			msclk <= 1'b0;
			busy_q <= 1'b0;
			sclk_q <= 1'b0;
			rd_q <= 1'b1;
		end else begin
			res <= next_res;
			sr <= next_sr;
			par <= next_par;
			cnt <= next_cnt;
			div <= next_div;
			idx <= next_idx;
			run <= next_run;
			hold <= next_hold;
			in_conv <= next_in_conv;
			chain_en <= next_chain_en;
			chain_q <= next_chain_q;
			late <= next_late;
			msclk <= next_msclk;
			busy_q <= conv_busy;
			sclk_q <= link.host_sclk;
			rd_q <= link.rd_n;
		end
	end

	// bridges the cycle between the conversion end and hold being registered
	assign link.busy = conv_busy || hold || (master && !run && !link.read_timing_chain_in && busy_q);
	assign link.late_read_flag = late;
	assign link.serial_result_out = sr[RW-1];
	assign link.data = par;
	assign link.dev_sclk = msclk ^ link.sclk_invert;
	assign link.sync = (master && run) ^ link.sync_invert;
	assign link.data_oe_n = !(selected && !serial);
	assign link.sdo_oe_n = !(selected && serial);
	assign link.dev_sclk_oe_n = !(selected && master);
	assign link.sync_oe_n = !(selected && master);
endmodule

// file: adc_readout_host.sv
`timescale 1ns/100ps
module adc_readout_host #(
	parameter int HALF = adc_readout_pkg::HOST_HALF,
	parameter int PAR_LOW = adc_readout_pkg::PAR_LOW
) (
	input wire logic pclk,
	input wire logic presetn,
	readout_if.host link,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	if (HALF < adc_readout_pkg::HOST_HALF || HALF > 255 || PAR_LOW < 2 || PAR_LOW > 255) begin : g_chk
		$error("host timing parameters out of range");
	end

	typedef enum {IDLE, ARM, PAR_LO, PAR_HI, SER_LO, SER_HI, M_WAIT} state_e;
	state_e st, next_st;
	logic [7:0] ctrl, next_ctrl, tmr, next_tmr;
	logic [31:0] acc, next_acc, dat, next_dat;
	logic [4:0] bits, next_bits;
	logic [1:0] chunk, next_chunk, last;
	logic done, next_done, late, next_late, cs_n, next_cs_n, rd_n, next_rd_n, sclk, next_sclk, s_q;
	logic wr, start, fin, s_now, may_read;
	logic [1:0] width;

	always_comb begin
		wr = psel && penable && pwrite;
		start = wr && paddr == adc_readout_pkg::CTRL_OFS && pwdata[adc_readout_pkg::CTRL_START];
		width = ctrl[adc_readout_pkg::CTRL_SEL_HI:adc_readout_pkg::CTRL_SEL_LO];
		may_read = !link.busy || ctrl[adc_readout_pkg::CTRL_IN_BUSY];
		s_now = link.dev_sclk ^ link.sclk_invert;
		unique case (width)
			adc_readout_pkg::SEL_P16: last = adc_readout_pkg::LAST16;
			adc_readout_pkg::SEL_P8: last = adc_readout_pkg::LAST8;
			default: last = 2'h0;
		endcase
		next_st = st;
		next_ctrl = ctrl;
		next_tmr = (tmr != 8'h00) ? tmr - 8'h01 : tmr;
		next_acc = acc;
		next_dat = dat;
		next_bits = bits;
		next_chunk = chunk;
		next_cs_n = cs_n;
		next_rd_n = rd_n;
		next_sclk = sclk;
		fin = 1'b0;
		if (wr && paddr == adc_readout_pkg::CTRL_OFS && st == IDLE) begin
			next_ctrl = pwdata[7:0];
		end
		unique case (st)
			IDLE: if (start) next_st = ARM;
			ARM: begin
				next_acc = '0;
				next_bits = 5'h00;
				next_chunk = 2'h0;
				if (width == adc_readout_pkg::SEL_SERIAL && !ctrl[adc_readout_pkg::CTRL_CLKSRC]) begin
					next_cs_n = 1'b0;
					next_rd_n = 1'b0;
					next_st = M_WAIT;
				end else if (may_read) begin
					next_cs_n = 1'b0;
					next_rd_n = 1'b0;
					next_sclk = 1'b0;
					next_tmr = (width == adc_readout_pkg::SEL_SERIAL) ? 8'(HALF) : 8'(PAR_LOW);
					next_st = (width == adc_readout_pkg::SEL_SERIAL) ? SER_LO : PAR_LO;
				end
			end
			PAR_LO: if (tmr == 8'h00) begin
				unique case (width)
					adc_readout_pkg::SEL_P16: next_acc = (acc << adc_readout_pkg::W16) | 32'(link.data);
					adc_readout_pkg::SEL_P8: next_acc = (acc << adc_readout_pkg::W8) | 32'(link.data);
					default: next_acc = 32'(link.data);
				endcase
				next_rd_n = 1'b1;
				next_tmr = 8'(PAR_LOW);
				next_chunk = chunk + 2'h1;
				if (chunk >= last) fin = 1'b1;
				else next_st = PAR_HI;
			end
			PAR_HI: if (tmr == 8'h00) begin
				next_rd_n = 1'b0;
				next_tmr = 8'(PAR_LOW);
				next_st = PAR_LO;
			end
			SER_LO: if (tmr == 8'h00 && may_read) begin
				next_sclk = 1'b1;
				next_tmr = 8'(HALF);
				next_st = SER_HI;
			end
			SER_HI: if (tmr == 8'h00) begin
				// falling edge: sample before the device moves on
				next_sclk = 1'b0;
				next_acc = {acc[30:0], link.serial_result_out};
				next_bits = bits + 5'h01;
				next_tmr = 8'(HALF);
				if (bits == adc_readout_pkg::SPI_BITS - 5'h01) fin = 1'b1;
				else next_st = SER_LO;
			end
			M_WAIT: if (s_now && !s_q && (link.sync ^ link.sync_invert)) begin
				next_acc = {acc[30:0], link.serial_result_out};
				next_bits = bits + 5'h01;
				if (bits == adc_readout_pkg::RES_BITS - 5'h01) fin = 1'b1;
			end
		endcase
		if (fin) begin
			next_dat = next_acc;
			next_cs_n = 1'b1;
			next_rd_n = 1'b1;
			next_sclk = 1'b0;
			next_st = IDLE;
		end
		next_done = fin || (done && !(wr && paddr == adc_readout_pkg::STAT_OFS && pwdata[adc_readout_pkg::ST_DONE]));
		next_late = link.late_read_flag ||
			(late && !(wr && paddr == adc_readout_pkg::STAT_OFS && pwdata[adc_readout_pkg::ST_LATE]));
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		unique case (paddr)
			adc_readout_pkg::CTRL_OFS: prdata = 32'(ctrl);
			adc_readout_pkg::STAT_OFS: begin
				prdata[adc_readout_pkg::ST_BUSY] = link.busy;
				prdata[adc_readout_pkg::ST_DONE] = done;
				prdata[adc_readout_pkg::ST_LATE] = late;
				prdata[adc_readout_pkg::ST_ACTIVE] = st != IDLE;
			end
			adc_readout_pkg::DATA_OFS: prdata = dat;
			default: pslverr = psel && penable;
		endcase
		pready = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= IDLE;
			ctrl <= adc_readout_pkg::CTRL_RST;
			tmr <= 8'h00;
			acc <= '0;
			dat <= '0;
			bits <= 5'h00;
			chunk <= 2'h0;
			done <= 1'b0;
			late <= 1'b0;
			cs_n <= 1'b1;
			rd_n <= 1'b1;
			sclk <= 1'b0;
			s_q <= 1'b0;
		end else begin
			st <= next_st;
			ctrl <= next_ctrl;
			tmr <= next_tmr;
			acc <= next_acc;
			dat <= next_dat;
			bits <= next_bits;
			chunk <= next_chunk;
			done <= next_done;
			late <= next_late;
			cs_n <= next_cs_n;
			rd_n <= next_rd_n;
			sclk <= next_sclk;
			s_q <= s_now;
		end
	end

	assign link.cs_n = cs_n;
	assign link.rd_n = rd_n;
	assign link.host_sclk = sclk;
	assign link.iface_sel_lo = ctrl[adc_readout_pkg::CTRL_SEL_LO];
	assign link.iface_sel_hi = ctrl[adc_readout_pkg::CTRL_SEL_HI];
	assign link.clock_source_select = ctrl[adc_readout_pkg::CTRL_CLKSRC];
	assign link.read_timing_chain_in = ctrl[adc_readout_pkg::CTRL_RDC];
	assign link.clock_divide_select = ctrl[adc_readout_pkg::CTRL_DIV];
	assign link.sclk_invert = ctrl[adc_readout_pkg::CTRL_SCLK_INV];
	assign link.sync_invert = ctrl[adc_readout_pkg::CTRL_SYNC_INV];
endmodule

// file: adc_readout_properties.sv
`timescale 1ns/100ps
module adc_readout_properties #(
	parameter int MASTER_HALF = adc_readout_pkg::MASTER_HALF,
	parameter int SLOW_HALF = adc_readout_pkg::SLOW_HALF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_busy,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic iface_sel_lo,
	input wire logic iface_sel_hi,
	input wire logic clock_source_select,
	input wire logic read_timing_chain_in,
	input wire logic clock_divide_select,
	input wire logic sclk_invert,
	input wire logic sync_invert,
	input wire logic dev_sclk,
	input wire logic dev_sclk_oe_n,
	input wire logic sync,
	input wire logic sync_oe_n,
	input wire logic serial_result_out,
	input wire logic sdo_oe_n,
	input wire logic data_oe_n,
	input wire logic busy,
	input wire logic late_read_flag
);
	logic sck, sck_d, act, ser;
	logic [4:0] rises, next_rises;
	logic [8:0] hi_len, next_hi_len;
	assign sck = dev_sclk ^ sclk_invert;
	assign act = sync ^ sync_invert;
	assign ser = iface_sel_lo && iface_sel_hi;
	// rising edges per frame and length of each high level
	always_comb begin
		next_rises = act ? rises + {4'h0, sck && !sck_d} : 5'h0;
		next_hi_len = sck ? hi_len + 9'h1 : 9'h0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_d <= 1'b0;
			rises <= 5'h0;
			hi_len <= 9'h0;
		end else begin
			sck_d <= sck;
			rises <= next_rises;
			hi_len <= next_hi_len;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_busy_follows; conv_busy |-> busy; endproperty
	a_busy_follows: assert property (p_busy_follows) else $error("busy low while converting");
	property p_busy_hold; $fell(conv_busy) && ser && !clock_source_select && !read_timing_chain_in |-> busy [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy fell before bits were sent");
	property p_released; (cs_n || rd_n) [*2] |-> data_oe_n && sdo_oe_n && dev_sclk_oe_n && sync_oe_n; endproperty
	a_released: assert property (p_released) else $error("output driven while deselected");
	property p_par_drive; (!cs_n && !rd_n && !ser) [*2] |-> !data_oe_n; endproperty
	a_par_drive: assert property (p_par_drive) else $error("parallel bus not driven");
	property p_master_drive; (!cs_n && !rd_n && ser && !clock_source_select) [*2] |-> !dev_sclk_oe_n && !sync_oe_n; endproperty
	a_master_drive: assert property (p_master_drive) else $error("master clock not driven");
	property p_slave_clk; clock_source_select [*2] |-> dev_sclk_oe_n && sync_oe_n; endproperty
	a_slave_clk: assert property (p_slave_clk) else $error("clock driven in slave mode");
	property p_late; late_read_flag |-> $past(conv_busy, 2) && !$past(conv_busy) ##1 !late_read_flag; endproperty
	a_late: assert property (p_late) else $error("late flag pulse misplaced");
	property p_count; $fell(act) |-> rises == 5'h12; endproperty
	a_count: assert property (p_count) else $error("frame clock count wrong");
	property p_half; act && sck_d && !sck |-> hi_len == 9'(clock_divide_select ? SLOW_HALF : MASTER_HALF); endproperty
	a_half: assert property (p_half) else $error("master clock half period wrong");
	property p_sdo_hold; act && sck && !sck_d |-> $stable(serial_result_out); endproperty
	a_sdo_hold: assert property (p_sdo_hold) else $error("data moved at sampling edge");
	c_frame: cover property ($fell(act));
	c_late: cover property (late_read_flag);
	c_par: cover property (!cs_n && !rd_n && !ser && !data_oe_n);
endmodule

// file: tb_adc_result_readout_port.sv
`timescale 1ns/100ps
module tb_adc_result_readout_port;
	localparam int MH = 2;
	localparam int SH = 8;
	logic pclk, presetn, conv_busy, psel, penable, pwrite, pready, pslverr, e, rdy;
	logic [17:0] conv_result, prev, want;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, st, c;
	int n_fail, tests_run, cyc;
	readout_if link_if();
	adc_readout_device #(.MASTER_HALF(MH), .SLOW_HALF(SH)) adc_readout_device_i (.pclk(pclk), .presetn(presetn),
		.link(link_if), .conv_busy(conv_busy), .conv_result(conv_result));
	adc_readout_host adc_readout_host_i (.pclk(pclk), .presetn(presetn), .link(link_if), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	adc_readout_properties #(.MASTER_HALF(MH), .SLOW_HALF(SH)) adc_readout_properties_i (.pclk(pclk),
		.presetn(presetn), .conv_busy(conv_busy), .cs_n(link_if.cs_n), .rd_n(link_if.rd_n),
		.iface_sel_lo(link_if.iface_sel_lo), .iface_sel_hi(link_if.iface_sel_hi),
		.clock_source_select(link_if.clock_source_select), .read_timing_chain_in(link_if.read_timing_chain_in),
		.clock_divide_select(link_if.clock_divide_select), .sclk_invert(link_if.sclk_invert),
		.sync_invert(link_if.sync_invert), .dev_sclk(link_if.dev_sclk), .dev_sclk_oe_n(link_if.dev_sclk_oe_n),
		.sync(link_if.sync), .sync_oe_n(link_if.sync_oe_n), .serial_result_out(link_if.serial_result_out),
		.sdo_oe_n(link_if.sdo_oe_n), .data_oe_n(link_if.data_oe_n), .busy(link_if.busy),
		.late_read_flag(link_if.late_read_flag));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			conclude();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer, then one idle cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer taken mid-cycle, where it stands until the sampling edge
		do begin
			@(negedge pclk);
			rdy = pready;
			q = prdata;
			e = pslverr;
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task conv(input logic [17:0] r, input int len);
		conv_busy <= 1'b1;
		repeat (len) @(posedge pclk);
		conv_busy <= 1'b0;
		conv_result <= r;
		prev = r;
		@(posedge pclk);
	endtask
	task start(input logic [31:0] v);
		apb(1'b1, adc_readout_pkg::CTRL_OFS, v | 32'h100);
	endtask
	task wait_done;
		st = 32'h0;
		for (int i = 0; i < 3000 && st[1] !== 1'b1; i++) begin
			apb(1'b0, adc_readout_pkg::STAT_OFS, 32'h0);
			st = q;
		end
		chk({31'h0, st[1]}, 32'h1);
		apb(1'b1, adc_readout_pkg::STAT_OFS, 32'h2);
	endtask
	function automatic logic [31:0] par_exp(input logic [1:0] s, input logic [17:0] r);
		case (s)
			adc_readout_pkg::SEL_P16: par_exp = {r, 14'h0};
			adc_readout_pkg::SEL_P8: par_exp = {8'h0, r, 6'h0};
			default: par_exp = {14'h0, r};
		endcase
	endfunction
	initial begin
		{presetn, conv_busy, psel, penable, pwrite} = 5'h0;
		conv_result = 18'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		q = $urandom(32'h2b7ed80f);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, adc_readout_pkg::CTRL_OFS, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("reset and unmapped test done");
		for (int k = 0; k < 6; k++) begin
			c = 32'(k % 3) | (k > 2 ? 32'h80 : 32'h0);
			apb(1'b1, adc_readout_pkg::CTRL_OFS, c);
			conv(18'($urandom), 20);
			if (k > 2)
				conv_busy <= 1'b1;
			start(c);
			wait_done();
			conv_busy <= 1'b0;
			apb(1'b0, adc_readout_pkg::DATA_OFS, 32'h0);
			chk(q, par_exp(c[1:0], prev));
		end
		$display("parallel test done");
		for (int k = 0; k < 4; k++) begin
			c = 32'h7 | (k == 1 ? 32'h8 : 32'h0) | (k > 1 ? 32'h80 : 32'h0);
			apb(1'b1, adc_readout_pkg::CTRL_OFS, c);
			conv(18'($urandom), 20);
			if (k > 1)
				conv_busy <= 1'b1;
			start(c);
			if (k == 3) begin
				repeat (30) @(posedge pclk);
				conv_busy <= 1'b0;
			end
			wait_done();
			conv_busy <= 1'b0;
			chk({31'h0, st[2]}, {31'h0, k == 3});
			apb(1'b0, adc_readout_pkg::DATA_OFS, 32'h0);
			if (k < 3)
				chk(q, {8'h0, prev, {6{c[3]}}});
		end
		apb(1'b1, adc_readout_pkg::STAT_OFS, 32'h4);
		apb(1'b0, adc_readout_pkg::STAT_OFS, 32'h0);
		chk({31'h0, q[2]}, 32'h0);
		$display("slave serial test done");
		for (int k = 0; k < 4; k++) begin
			c = 32'h3 | (k[0] ? 32'h10 : 32'h0) | (k[1] ? 32'h8 : 32'h0) | (32'($urandom_range(3)) << 5);
			apb(1'b1, adc_readout_pkg::CTRL_OFS, c);
			if (k[1]) begin
				conv(18'($urandom), 400);
				want = prev;
			end
			start(c);
			conv(18'($urandom), k[1] ? 400 : 20);
			if (!k[1])
				want = prev;
			wait_done();
			apb(1'b0, adc_readout_pkg::DATA_OFS, 32'h0);
			chk(q, {14'h0, want});
		end
		$display("master serial test done");
		conclude();
	end
endmodule
